// ===== rfa_carrier_base_word_regs.sv
// Purpose: radio address filter and synthesizer frequency configuration bank on classic wishbone
// Assumes: one 50 MHz clock, synchronous active-low reset, 8-bit data in byte lane 0
// Notes: synthesizer word is in steps of the oscillator frequency over 65536
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RL1] Hold 8-bit filter address, reset zero, compared with received packet addresses.
// [RL2] Broadcast modes also accept address zero and optionally 255.
// [RL3] Two-bit check mode: none, strict, zero broadcast, zero and 255 broadcast.
// [RL4] Channel index times channel spacing is added to the base frequency.
// [RL5] In receive the 5-bit IF word is subtracted; it also feeds the mixer.
// [RL6] IF equals oscillator over 1024 times IF word; word resets to 01111.
// [RL7] Signed offset word adds steps of oscillator over 16384 to base.
// [RL8] Correction strobe or automatic correction adds frequency estimate into offset word.
// [RL9] 24-bit carrier word from three bytes; base is oscillator over 65536 times it.
// [RL10] Carrier word bits 23:22 read 01 and ignore writes.
// [RL11] Writes land on the edge after the strobe; fixed bits read fixed; reset restores.
module rfa_carrier_base_word_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [rfa_pkg::ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic [7:0] pkt_addr,
  input wire logic pkt_addr_valid,
  output logic addr_accept,
  output logic addr_result_valid,
  input wire logic [7:0] carrier_base_word_estimate_value,
  input wire logic carrier_base_word_estimate_valid,
  output logic rx_mode,
  output logic [4:0] intermediate_carrier_base_word_word,
  output logic [23:0] synth_carrier_base_word_word
);
  import rfa_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] filt_addr;
    logic [7:0] channel_number_value;
    logic [4:0] ifw;
    logic [7:0] off;
    logic [5:0] hi;
    logic [7:0] mid;
    logic [7:0] lo;
    logic [3:0] ctrl;
    logic [7:0] spacing;
    logic [4:0] ifo;
    logic [23:0] synth;
  } rfa_top_s;

  rfa_top_s r, n;
  logic req;
  logic wr;
  logic apply;
  rfa_idx_t idx;
  logic [7:0] rbyte;
  logic [23:0] base_word;
  logic [15:0] channel_number_value_prod;
  logic [23:0] off_term;
  logic [23:0] if_term;

  rfa_filt_if fi ();

  rfa_addr_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .fi(fi)
  );

  assign fi.filt_addr = r.filt_addr;
  assign fi.mode = rfa_chk_e'(r.ctrl[1:0]);
  assign fi.pkt_addr = pkt_addr;
  assign fi.pkt_valid = pkt_addr_valid;

  always_comb begin
    n = r;
    idx = wb_adr[ADR_W-1:2];
    req = wb_cyc & wb_stb & ~r.ack;
    wr = req & wb_we & wb_sel[0];
    base_word = {CARRIER_FIXED, r.hi, r.mid, r.lo}; // RL9 RL10
    channel_number_value_prod = r.channel_number_value * r.spacing; // RL4
    off_term = {{14{r.off[7]}}, r.off, 2'b00}; // RL7
    if_term = {13'h0000, r.ifw, 6'h00}; // RL6
    // read mux, unmapped indices answer zero
    unique case (idx)
      IDX_FILT_ADDR: rbyte = r.filt_addr;
      IDX_CHANNEL_NUMBER_VALUE: rbyte = r.channel_number_value;
      IDX_IF_CTRL: rbyte = {3'b000, r.ifw}; // RL11
      IDX_OFF_CTRL: rbyte = r.off;
      IDX_CARRIER_HI: rbyte = {CARRIER_FIXED, r.hi}; // RL10
      IDX_CARRIER_MID: rbyte = r.mid;
      IDX_CARRIER_LO: rbyte = r.lo;
      IDX_CTRL: rbyte = {4'h0, r.ctrl};
      IDX_SPACING: rbyte = r.spacing;
      default: rbyte = 8'h00;
    endcase
    n.ack = req;
    if (req) begin
      n.rdat = {24'h000000, rbyte};
    end
    if (wr) begin
      unique case (idx) // RL11
        IDX_FILT_ADDR: n.filt_addr = wb_dat_w[7:0]; // RL1
        IDX_CHANNEL_NUMBER_VALUE: n.channel_number_value = wb_dat_w[7:0];
        IDX_IF_CTRL: n.ifw = wb_dat_w[4:0];
        IDX_OFF_CTRL: n.off = wb_dat_w[7:0];
        IDX_CARRIER_HI: n.hi = wb_dat_w[5:0]; // RL10
        IDX_CARRIER_MID: n.mid = wb_dat_w[7:0];
        IDX_CARRIER_LO: n.lo = wb_dat_w[7:0];
        IDX_CTRL: n.ctrl = wb_dat_w[3:0];
        IDX_SPACING: n.spacing = wb_dat_w[7:0];
        default: n.ctrl = n.ctrl;
      endcase
    end
    // correction adds on top of a same-cycle offset write so neither is lost
    apply = (wr & (idx == IDX_CTRL) & wb_dat_w[CTRL_APPLY_BIT])
          | (r.ctrl[CTRL_AUTO_BIT] & carrier_base_word_estimate_valid);
    if (apply) begin
      n.off = n.off + carrier_base_word_estimate_value; // RL8
    end
    n.ifo = r.ifw; // RL5
    if (r.ctrl[CTRL_RX_BIT]) begin
      n.synth = base_word + {8'h00, channel_number_value_prod} + off_term - if_term; // RL5
    end else begin
      n.synth = base_word + {8'h00, channel_number_value_prod} + off_term; // RL4 RL7
    end
    if (!rst_n) begin
      n.ack = 1'b0;
      n.rdat = 32'h00000000;
      n.filt_addr = RST_FILT_ADDR; // RL1
      n.channel_number_value = RST_CHANNEL_NUMBER_VALUE;
      n.ifw = RST_IF; // RL6
      n.off = RST_OFF;
      n.hi = RST_CARRIER_HI;
      n.mid = RST_CARRIER_MID;
      n.lo = RST_CARRIER_LO;
      n.ctrl = RST_CTRL;
      n.spacing = RST_SPACING;
      n.ifo = RST_IF;
      n.synth = 24'h000000;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign wb_ack = r.ack;
  assign wb_dat_r = r.rdat;
  assign addr_accept = fi.accept;
  assign addr_result_valid = fi.result_valid;
  assign rx_mode = r.ctrl[CTRL_RX_BIT];
  assign intermediate_carrier_base_word_word = r.ifo;
  assign synth_carrier_base_word_word = r.synth;

  property p_ack_next;
    @(posedge clk) disable iff (!rst_n) wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not given for exactly one cycle"); // RL11
  property p_filt_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_FILT_ADDR |=> r.filt_addr == $past(wb_dat_w[7:0]) && fi.filt_addr == r.filt_addr;
  endproperty
  a_filt_wr: assert property (p_filt_wr) else $error("filter address write lost"); // RL1
  property p_hi_read;
    @(posedge clk) disable iff (!rst_n)
      req && !wb_we && idx == IDX_CARRIER_HI |=> wb_ack && wb_dat_r[7:6] == 2'b01 && wb_dat_r[5:0] == $past(r.hi);
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("carrier high byte top bits not 01"); // RL10
  property p_hi_fixed;
    @(posedge clk) disable iff (!rst_n) wr && idx == IDX_CARRIER_HI |=> r.hi == $past(wb_dat_w[5:0]);
  endproperty
  a_hi_fixed: assert property (p_hi_fixed) else $error("carrier high byte write lost"); // RL10
  property p_if_reset;
    @(posedge clk) $past(!rst_n) && rst_n |-> r.ifw == 5'h0F && r.filt_addr == 8'h00 && r.off == 8'h00;
  endproperty
  a_if_reset: assert property (p_if_reset) else $error("reset values not restored"); // RL6
  property p_channel_number_value;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !rx_mode && r.off == 8'h00 |=> synth_carrier_base_word_word == $past(base_word) + {8'h00, $past(channel_number_value_prod)};
  endproperty
  a_channel_number_value: assert property (p_channel_number_value) else $error("channel term wrong in synthesizer word"); // RL4
  property p_rx_if;
    @(posedge clk) disable iff (!rst_n)
      rst_n && rx_mode && r.channel_number_value == 8'h00 && r.off == 8'h00 |=> synth_carrier_base_word_word == $past(base_word) - $past(if_term);
  endproperty
  a_rx_if: assert property (p_rx_if) else $error("IF not subtracted in receive"); // RL5
  property p_off;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !rx_mode && r.channel_number_value == 8'h00 |=> synth_carrier_base_word_word == $past(base_word) + $past(off_term);
  endproperty
  a_off: assert property (p_off) else $error("offset term wrong in synthesizer word"); // RL7
  property p_base;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !rx_mode && r.channel_number_value == 8'h00 && r.off == 8'h00
        |=> synth_carrier_base_word_word == {2'b01, $past(r.hi), $past(r.mid), $past(r.lo)};
  endproperty
  a_base: assert property (p_base) else $error("base word not assembled from three bytes"); // RL9
  property p_corr;
    @(posedge clk) disable iff (!rst_n)
      apply && !(wr && idx == IDX_OFF_CTRL) |=> r.off == 8'($past(r.off) + $past(carrier_base_word_estimate_value));
  endproperty
  a_corr: assert property (p_corr) else $error("frequency estimate not added to offset"); // RL8

  property p_ack_once;
    @(posedge clk) disable iff (!rst_n)
      wb_ack |=> !wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle"); // RL11

  property p_ack_idle;
    @(posedge clk) disable iff (!rst_n)
      !(wb_cyc && wb_stb) |=> !wb_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without a request"); // RL11

  property p_rdat_hold;
    @(posedge clk) disable iff (!rst_n)
      !(wb_cyc && wb_stb && !wb_ack) |=> $stable(wb_dat_r);
  endproperty
  a_rdat_hold: assert property (p_rdat_hold) else $error("read data changed without a request"); // RL11

  property p_rdat_upper;
    @(posedge clk) disable iff (!rst_n)
      wb_ack |-> wb_dat_r[31:8] == 24'h000000;
  endproperty
  a_rdat_upper: assert property (p_rdat_upper) else $error("upper read data bits not zero"); // RL11

  property p_unmapped_rd;
    @(posedge clk) disable iff (!rst_n)
      req && !wb_we && (idx < IDX_FILT_ADDR || idx > IDX_SPACING || (idx > IDX_CARRIER_LO && idx < IDX_CTRL))
        |=> wb_dat_r == 32'h00000000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped index read not zero"); // RL11

  property p_unmapped_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx > IDX_CARRIER_LO && idx < IDX_CTRL
        |=> r.channel_number_value == $past(r.channel_number_value) && r.mid == $past(r.mid) && r.lo == $past(r.lo);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write changed a register"); // RL11

  property p_channel_number_value_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_CHANNEL_NUMBER_VALUE |=> r.channel_number_value == $past(wb_dat_w[7:0]);
  endproperty
  a_channel_number_value_wr: assert property (p_channel_number_value_wr) else $error("channel index write lost"); // RL4

  property p_spacing_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_SPACING |=> r.spacing == $past(wb_dat_w[7:0]);
  endproperty
  a_spacing_wr: assert property (p_spacing_wr) else $error("channel spacing write lost"); // RL4

  property p_if_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_IF_CTRL |=> r.ifw == $past(wb_dat_w[4:0]);
  endproperty
  a_if_wr: assert property (p_if_wr) else $error("IF word write lost"); // RL6

  property p_if_read;
    @(posedge clk) disable iff (!rst_n)
      req && !wb_we && idx == IDX_IF_CTRL |=> wb_dat_r[7:5] == 3'b000 && wb_dat_r[4:0] == $past(r.ifw);
  endproperty
  a_if_read: assert property (p_if_read) else $error("IF control read wrong"); // RL6

  property p_if_out;
    @(posedge clk) disable iff (!rst_n)
      rst_n |=> intermediate_carrier_base_word_word == $past(r.ifw);
  endproperty
  a_if_out: assert property (p_if_out) else $error("mixer IF word does not follow register"); // RL5

  property p_mid_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_CARRIER_MID |=> r.mid == $past(wb_dat_w[7:0]);
  endproperty
  a_mid_wr: assert property (p_mid_wr) else $error("carrier middle byte write lost"); // RL9

  property p_lo_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_CARRIER_LO |=> r.lo == $past(wb_dat_w[7:0]);
  endproperty
  a_lo_wr: assert property (p_lo_wr) else $error("carrier low byte write lost"); // RL9

  property p_off_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_OFF_CTRL && !apply |=> r.off == $past(wb_dat_w[7:0]);
  endproperty
  a_off_wr: assert property (p_off_wr) else $error("offset word write lost"); // RL7

  property p_off_idle;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !apply && !(wr && idx == IDX_OFF_CTRL) |=> r.off == $past(r.off);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("offset word changed without cause"); // RL8

  property p_ctrl_wr;
    @(posedge clk) disable iff (!rst_n)
      wr && idx == IDX_CTRL |=> r.ctrl == $past(wb_dat_w[3:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("check mode write lost"); // RL3

  property p_ctrl_read;
    @(posedge clk) disable iff (!rst_n)
      req && !wb_we && idx == IDX_CTRL |=> wb_dat_r[7:4] == 4'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("apply strobe or unused control bits read set"); // RL8

  property p_result_pulse;
    @(posedge clk) disable iff (!rst_n)
      rst_n |=> addr_result_valid == $past(pkt_addr_valid);
  endproperty
  a_result_pulse: assert property (p_result_pulse) else $error("filter result not one cycle after packet"); // RL1

  property p_accept_hold;
    @(posedge clk) disable iff (!rst_n)
      rst_n && !pkt_addr_valid |=> addr_accept == $past(addr_accept);
  endproperty
  a_accept_hold: assert property (p_accept_hold) else $error("filter verdict changed without packet"); // RL1
endmodule : rfa_carrier_base_word_regs
`default_nettype wire

// ===== rfa_pkg.sv
// Purpose: constants and types shared by the radio frequency and address configuration bank
// Assumes: 8-bit registers on a 32-bit classic wishbone bus, one word per register
// Notes: byte address of a register is four times its index
package rfa_pkg;
  localparam int ADR_W = 18;
  typedef logic [15:0] rfa_idx_t;
  localparam rfa_idx_t IDX_FILT_ADDR = 16'hDF05;
  localparam rfa_idx_t IDX_CHANNEL_NUMBER_VALUE = 16'hDF06;
  localparam rfa_idx_t IDX_IF_CTRL = 16'hDF07;
  localparam rfa_idx_t IDX_OFF_CTRL = 16'hDF08;
  localparam rfa_idx_t IDX_CARRIER_HI = 16'hDF09;
  localparam rfa_idx_t IDX_CARRIER_MID = 16'hDF0A;
  localparam rfa_idx_t IDX_CARRIER_LO = 16'hDF0B;
  localparam rfa_idx_t IDX_CTRL = 16'hDF40;
  localparam rfa_idx_t IDX_SPACING = 16'hDF41;
  localparam logic [7:0] RST_FILT_ADDR = 8'h00;
  localparam logic [7:0] RST_CHANNEL_NUMBER_VALUE = 8'h00;
  localparam logic [4:0] RST_IF = 5'h0F;
  localparam logic [7:0] RST_OFF = 8'h00;
  localparam logic [5:0] RST_CARRIER_HI = 6'h1E;
  localparam logic [7:0] RST_CARRIER_MID = 8'hC4;
  localparam logic [7:0] RST_CARRIER_LO = 8'hEC;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [7:0] RST_SPACING = 8'h10;
  localparam logic [1:0] CARRIER_FIXED = 2'h1;
  localparam int CTRL_RX_BIT = 2;
  localparam int CTRL_AUTO_BIT = 3;
  localparam int CTRL_APPLY_BIT = 4;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ALL = 8'hFF;
  typedef enum logic [1:0] {CHK_NONE, CHK_ADDR, CHK_ZERO, CHK_BOTH} rfa_chk_e;
endpackage : rfa_pkg

// ===== rfa_filt_if.sv
// Purpose: carries filter settings and packet addresses between the bank and the address filter
// Assumes: all signals belong to the single system clock
// Notes: cfg is the bank end, filt the filter end
`timescale 1ns/10ps
`default_nettype none
interface rfa_filt_if;
  logic [7:0] filt_addr;
  rfa_pkg::rfa_chk_e mode;
  logic [7:0] pkt_addr;
  logic pkt_valid;
  logic accept;
  logic result_valid;
  modport cfg (output filt_addr, output mode, output pkt_addr, output pkt_valid,
               input accept, input result_valid);
  modport filt (input filt_addr, input mode, input pkt_addr, input pkt_valid,
                output accept, output result_valid);
endinterface : rfa_filt_if
`default_nettype wire

// ===== rfa_addr_filter.sv
// Purpose: decides whether a received packet address passes the address check
// Assumes: pkt_valid is a one-cycle pulse with pkt_addr
// Notes: result appears one cycle after the pulse and stands until the next one
`timescale 1ns/10ps
`default_nettype none
module rfa_addr_filter (
  input wire logic clk,
  input wire logic rst_n,
  rfa_filt_if.filt fi
);
  import rfa_pkg::*;
  typedef struct packed {
    logic accept;
    logic valid;
  } rfa_flt_s;
  rfa_flt_s r, n;
  logic hit;

  always_comb begin
    n = r;
    hit = (fi.pkt_addr == fi.filt_addr); // RL1
    n.valid = fi.pkt_valid;
    if (fi.pkt_valid) begin
      unique case (fi.mode) // RL3
        CHK_NONE: n.accept = 1'b1;
        CHK_ADDR: n.accept = hit;
        CHK_ZERO: n.accept = hit | (fi.pkt_addr == BCAST_ZERO); // RL2
        CHK_BOTH: n.accept = hit | (fi.pkt_addr == BCAST_ZERO) | (fi.pkt_addr == BCAST_ALL); // RL2
      endcase
    end
    if (!rst_n) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign fi.accept = r.accept;
  assign fi.result_valid = r.valid;

  property p_no_check;
    @(posedge clk) disable iff (!rst_n) fi.pkt_valid && fi.mode == CHK_NONE |=> fi.accept && fi.result_valid;
  endproperty
  a_no_check: assert property (p_no_check) else $error("no-check mode rejected a packet"); // RL3
  property p_strict;
    @(posedge clk) disable iff (!rst_n)
      fi.pkt_valid && fi.mode == CHK_ADDR && fi.pkt_addr != fi.filt_addr |=> !fi.accept;
  endproperty
  a_strict: assert property (p_strict) else $error("foreign address accepted without broadcast"); // RL1
  property p_bcast;
    @(posedge clk) disable iff (!rst_n)
      fi.pkt_valid && fi.mode == CHK_BOTH && (fi.pkt_addr == BCAST_ALL || fi.pkt_addr == BCAST_ZERO) |=> fi.accept;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast address rejected"); // RL2
  property p_zero_only;
    @(posedge clk) disable iff (!rst_n)
      fi.pkt_valid && fi.mode == CHK_ZERO && fi.pkt_addr == BCAST_ALL && fi.filt_addr != BCAST_ALL |=> !fi.accept;
  endproperty
  a_zero_only: assert property (p_zero_only) else $error("255 accepted in zero-only broadcast mode"); // RL3
endmodule : rfa_addr_filter
`default_nettype wire

// ===== rfa_carrier_base_word_regs_tb_top.sv
// Purpose: self-checking bench for the radio frequency and address configuration bank
// Assumes: classic wishbone, one-cycle registered ack, 8-bit data in byte lane 0
// Notes: expected synthesizer words are computed here from the register values written
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module rfa_carrier_base_word_regs_tb_top;
  import rfa_pkg::*;
  logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [7:0] pkt_addr, carrier_base_word_estimate_value;
  logic pkt_addr_valid, addr_accept, addr_result_valid, carrier_base_word_estimate_valid, rx_mode;
  logic [4:0] intermediate_carrier_base_word_word;
  logic [23:0] synth_carrier_base_word_word;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  rfa_idx_t ridx [9] = '{IDX_FILT_ADDR, IDX_CHANNEL_NUMBER_VALUE, IDX_IF_CTRL, IDX_OFF_CTRL, IDX_CARRIER_HI,
                         IDX_CARRIER_MID, IDX_CARRIER_LO, IDX_CTRL, IDX_SPACING};
  logic [7:0] rexp [9] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h5E, 8'hC4, 8'hEC, 8'h00, 8'h10};
  logic [7:0] paddr [4] = '{8'h42, 8'h00, 8'hFF, 8'h13};
  logic [3:0] ptbl [4] = '{4'hF, 4'h8, 4'hC, 4'hE};

  rfa_carrier_base_word_regs rfa_carrier_base_word_regs_i (.clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .pkt_addr(pkt_addr), .pkt_addr_valid(pkt_addr_valid), .addr_accept(addr_accept),
    .addr_result_valid(addr_result_valid), .carrier_base_word_estimate_value(carrier_base_word_estimate_value),
    .carrier_base_word_estimate_valid(carrier_base_word_estimate_valid), .rx_mode(rx_mode),
    .intermediate_carrier_base_word_word(intermediate_carrier_base_word_word), .synth_carrier_base_word_word(synth_carrier_base_word_word));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end

  task automatic wb_xfer(input logic we, input rfa_idx_t idx, input logic [7:0] wd, output logic [31:0] rd);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h1;
    wb_dat_w <= {24'h000000, wd};
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  task automatic wr(input rfa_idx_t idx, input logic [7:0] wd);
    logic [31:0] junk;
    wb_xfer(1'b1, idx, wd, junk);
  endtask : wr

  task automatic rd_chk(input rfa_idx_t idx, input logic [7:0] e);
    logic [31:0] v;
    wb_xfer(1'b0, idx, 8'h00, v);
    `CHK("register", {24'h000000, e}, v)
  endtask : rd_chk

  // synthesizer word lags a register write by one flop
  task automatic chk_synth(input logic [23:0] e);
    repeat (3) @(posedge clk);
    #1;
    `CHK("synth_carrier_base_word_word", e, synth_carrier_base_word_word)
    @(posedge clk);
  endtask : chk_synth

  task automatic pkt(input logic [7:0] a, input logic e);
    pkt_addr <= a;
    pkt_addr_valid <= 1'b1;
    @(posedge clk);
    pkt_addr_valid <= 1'b0;
    #1;
    `CHK("addr_result_valid", 1'b1, addr_result_valid)
    `CHK("addr_accept", e, addr_accept)
    @(posedge clk);
  endtask : pkt

  function automatic logic [23:0] synth_exp(logic [23:0] base, logic [7:0] ch, logic [7:0] off,
                                            logic [4:0] ifw, logic rx);
    logic [23:0] s;
    s = base + 24'(ch) * 24'(RST_SPACING) + {{16{off[7]}}, off} * 24'h000004;
    synth_exp = rx ? s - 24'(ifw) * 24'h000040 : s;
  endfunction : synth_exp

  initial begin
    rst_n <= 1'b0;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_adr <= '0;
    wb_sel <= 4'h0;
    wb_dat_w <= '0;
    pkt_addr <= 8'h00;
    pkt_addr_valid <= 1'b0;
    carrier_base_word_estimate_value <= 8'h00;
    carrier_base_word_estimate_valid <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd_chk(ridx[i], rexp[i]);
    chk_synth(24'h5EC4EC);
    `CHK("intermediate_carrier_base_word_word", 5'h0F, intermediate_carrier_base_word_word)
    wr(16'hDF20, 8'hAA);
    rd_chk(16'hDF20, 8'h00);
    wr(IDX_CARRIER_HI, 8'hFF);
    rd_chk(IDX_CARRIER_HI, 8'h7F);
    wr(IDX_CARRIER_HI, 8'h1B);
    wr(IDX_CARRIER_MID, 8'h12);
    wr(IDX_CARRIER_LO, 8'h34);
    rd_chk(IDX_CARRIER_HI, 8'h5B);
    chk_synth(24'h5B1234);
    wr(IDX_CHANNEL_NUMBER_VALUE, 8'h03);
    wr(IDX_OFF_CTRL, 8'hFE);
    chk_synth(synth_exp(24'h5B1234, 8'h03, 8'hFE, 5'h0F, 1'b0));
    wr(IDX_IF_CTRL, 8'hFF);
    rd_chk(IDX_IF_CTRL, 8'h1F);
    wr(IDX_CTRL, 8'h04);
    chk_synth(synth_exp(24'h5B1234, 8'h03, 8'hFE, 5'h1F, 1'b1));
    `CHK("intermediate_carrier_base_word_word", 5'h1F, intermediate_carrier_base_word_word)
    `CHK("rx_mode", 1'b1, rx_mode)
    carrier_base_word_estimate_value <= 8'h05;
    wr(IDX_CTRL, 8'h10);
    rd_chk(IDX_OFF_CTRL, 8'h03);
    rd_chk(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h08);
    carrier_base_word_estimate_value <= 8'hFC;
    carrier_base_word_estimate_valid <= 1'b1;
    @(posedge clk);
    carrier_base_word_estimate_valid <= 1'b0;
    @(posedge clk);
    rd_chk(IDX_OFF_CTRL, 8'hFF);
    wr(IDX_FILT_ADDR, 8'h42);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_CTRL, 8'(m));
      for (int k = 0; k < 4; k++) pkt(paddr[k], ptbl[m][3-k]);
    end
    wr(IDX_SPACING, 8'h20);
    rd_chk(IDX_SPACING, 8'h20);
    chk_synth(24'h5B1290);
    // mid-run reset must bring every register back
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd_chk(ridx[i], rexp[i]);
    wr(IDX_CTRL, 8'h04);
    chk_synth(24'h5EC12C);
    end_sim();
  end
endmodule : rfa_carrier_base_word_regs_tb_top
`default_nettype wire
